// *** hw/chan_cfg_pkg.sv ***
// Package: register map, field layout, reset values and decode tables
package chan_cfg_pkg;
  localparam int          NUM_CHANNELS       = 4;
  localparam logic [7:0]  ADDR_CHAN_CTRL     = 8'h00;
  localparam logic [7:0]  ADDR_EMPHASIS      = 8'h15;
  localparam logic [7:0]  ADDR_SWING         = 8'h2D;
  localparam logic [7:0]  ADDR_ADAPT_OVR     = 8'h2F;
  localparam logic [7:0]  ADDR_ADAPT_START   = 8'h39;
  localparam logic [7:0]  ADDR_TABLE_FIRST   = 8'h40;
  localparam logic [7:0]  ADDR_TABLE_LAST    = 8'h5F;
  localparam logic [7:0]  ADDR_SELECT        = 8'hFF;
  localparam int          CHAN_RESET_BIT     = 2;
  localparam int          ADAPT_OVR_BIT      = 3;
  localparam int          EMPH_RANGE_BIT     = 6;
  localparam int          SEL_CHAN_EN_BIT    = 2;
  localparam int          SEL_BCAST_BIT      = 3;
  localparam logic [7:0]  EMPH_MASK          = 8'h47;
  localparam logic [7:0]  SWING_MASK         = 8'h07;
  localparam logic [7:0]  ADAPT_OVR_MASK     = 8'h08;
  localparam logic [7:0]  ADAPT_START_MASK   = 8'h1F;
  localparam logic [7:0]  SELECT_MASK        = 8'h0F;
  localparam logic [7:0]  CHAN_CTRL_MASK     = 8'h04;
  localparam logic [7:0]  EMPH_RESET         = 8'h00;
  localparam logic [7:0]  SWING_RESET        = 8'h00;
  localparam logic [7:0]  ADAPT_OVR_RESET    = 8'h00;
  localparam logic [7:0]  ADAPT_START_RESET  = 8'h00;
  localparam logic [7:0]  SELECT_RESET       = 8'h00;
  // Default boost candidates, stage0..3 as 2-bit fields, index 0 first
  localparam logic [7:0] BOOST_DEFAULT [32] = '{
    8'h00, 8'h01, 8'h04, 8'h10, 8'h40, 8'h08, 8'h02, 8'h80,
    8'h03, 8'h0C, 8'h30, 8'h41, 8'h50, 8'hC0, 8'h60, 8'h90,
    8'h88, 8'h82, 8'hA0, 8'h46, 8'h52, 8'h8C, 8'hB0, 8'hC8,
    8'h57, 8'h5D, 8'h69, 8'h75, 8'hD5, 8'h99, 8'h96, 8'hA5};
  // Swing in millivolts: 600 + 100*code
  localparam logic [10:0] SWING_BASE_MV      = 11'h258;
  localparam logic [10:0] SWING_STEP_MV      = 11'h064;
  // Emphasis magnitude in tenths of a dB, indexed by code, per range
  localparam logic [6:0]  EMPH_LOW_RANGE [8] = '{
    7'h00, 7'h09, 7'h14, 7'h1C, 7'h21, 7'h27, 7'h2D, 7'h38};
  localparam logic [6:0]  EMPH_FULL_RANGE [8] = '{
    7'h00, 7'h0F, 7'h23, 7'h32, 7'h3C, 7'h4B, 7'h5A, 7'h78};
endpackage : chan_cfg_pkg

// *** hw/boost_table_mem.sv ***
// Per-channel 32-entry candidate boost table with registered read
`timescale 1ns/1ps
module boost_table_mem
  import chan_cfg_pkg::*;
(
  input  wire logic       mclk_in,
  input  wire logic       ce_in,
  input  wire logic       restore_in,
  input  wire logic       wr_en_in,
  input  wire logic [4:0] wr_idx_in,
  input  wire logic [7:0] wr_data_in,
  input  wire logic [4:0] rd_idx_in,
  input  wire logic [4:0] start_idx_in,
  output logic      [7:0] rd_data_out,
  output logic      [7:0] start_entry_out
);
  logic [7:0] mem      [32];
  logic [7:0] next_mem [32];

  always_comb begin
    next_mem = mem;
    if (restore_in) begin
      next_mem = BOOST_DEFAULT;
    end else if (wr_en_in) begin
      next_mem[wr_idx_in] = wr_data_in;
    end
  end

  // Table has no reset of its own; power-up default comes via restore_in
  always_ff @(posedge mclk_in) begin
    if (ce_in) begin
      mem             <= next_mem;
      rd_data_out     <= mem[rd_idx_in];
      start_entry_out <= mem[start_idx_in];
    end
  end
endmodule : boost_table_mem

// *** hw/channel_driver_config_regs.sv ***
// Shared and per-channel configuration registers with setting decode
//
// Functional notes
// RULE1: Override bit 3 of adapt_override_control picks the programmed start index, otherwise index zero.
// RULE2: With override on, the start index is bits 4:0 of adapt_start_index.
// RULE3: Start index n selects the table entry at 0x40+n within 0x40..0x5f.
// RULE4: Index zero starts adaptation at entry 0x40 and steps upward.
// RULE5: Override works with rewritten tables; the stored table contents are used.
// RULE6: Swing code n in output_swing_control bits 2:0 gives 600+100n mV.
// RULE7: Emphasis comes from emphasis_control bits 2:0 plus range bit 6, fifteen settings.
// RULE8: Code 000 is 0.0 dB for either range; 111 with range clear is -12.0 dB.
// RULE9: Range set decodes 001..111 as -0.9,-2.0,-2.8,-3.3,-3.9,-4.5,-5.6 dB.
// RULE10: Range clear decodes 001..111 as -1.5,-3.5,-5.0,-6.0,-7.5,-9.0,-12.0 dB.
// RULE11: Shared registers exist once; each channel has its own configuration copy.
// RULE12: The shared group holds the selection of the target channel copy.
// RULE13: Software leaves undescribed registers unwritten.
// RULE14: Writing 1 to bit 2 of channel register 0x00 restores the boost table defaults.
// RULE15: Bit 2 of 0xff steers accesses to shared group when clear, channel group when set.
// RULE16: Bits 1:0 of 0xff pick one of four channel copies.
// RULE17: Undefined bits read zero and writes to them change nothing.
`timescale 1ns/1ps
module channel_driver_config_regs
  import chan_cfg_pkg::*;
(
  input  wire logic        mclk_in,
  input  wire logic        rstn_in,
  input  wire logic        ce_in,
  input  wire logic        wr_in,
  input  wire logic        rd_in,
  input  wire logic [7:0]  addr_in,
  input  wire logic [7:0]  wdata_in,
  output logic      [7:0]  rdata_out,
  output logic             rvalid_out,
  output logic      [19:0] adapt_start_idx_out,
  output logic      [31:0] adapt_start_entry_out,
  output logic      [43:0] swing_mv_out,
  output logic      [27:0] emph_tenth_db_out
);
  ////////////////////////////////////////////////////////////////////////////
  logic [7:0] select_reg;
  logic [7:0] next_select_reg;
  logic [7:0] emph     [NUM_CHANNELS];
  logic [7:0] swing    [NUM_CHANNELS];
  logic [7:0] ovr      [NUM_CHANNELS];
  logic [7:0] start    [NUM_CHANNELS];
  logic [7:0] next_emph  [NUM_CHANNELS];
  logic [7:0] next_swing [NUM_CHANNELS];
  logic [7:0] next_ovr   [NUM_CHANNELS];
  logic [7:0] next_start [NUM_CHANNELS];
  logic       chan_mode;
  logic [1:0] chan_sel;
  logic       in_table;
  logic [4:0] tbl_idx;
  logic [NUM_CHANNELS-1:0] hit;
  logic [NUM_CHANNELS-1:0] tbl_wr;
  logic [NUM_CHANNELS-1:0] restore;
  logic [7:0] tbl_rd   [NUM_CHANNELS];
  logic [7:0] tbl_start[NUM_CHANNELS];
  logic [4:0] eff_idx  [NUM_CHANNELS];
  logic       rd_tbl_q;
  logic [1:0] rd_chan_q;
  logic [7:0] rd_reg_q;
  logic       next_rd_tbl;
  logic [7:0] next_rd_reg;
  logic       rvalid_q;

  assign chan_mode = select_reg[SEL_CHAN_EN_BIT];                    // [RULE15]
  assign chan_sel  = select_reg[1:0];                                // [RULE16]
  assign in_table  = (addr_in >= ADDR_TABLE_FIRST) && (addr_in <= ADDR_TABLE_LAST);
  assign tbl_idx   = addr_in[4:0];

  ////////////////////////////////////////////////////////////////////////////
  // Target decode; broadcast writes all copies when bit 3 and bit 2 set
  always_comb begin
    for (int c = 0; c < NUM_CHANNELS; c++) begin
      hit[c] = wr_in && chan_mode && (addr_in != ADDR_SELECT) &&
               (select_reg[SEL_BCAST_BIT] || (chan_sel == c[1:0]));  // [RULE11] [RULE16]
      tbl_wr[c]  = hit[c] && in_table;
      restore[c] = !rstn_in || (hit[c] && addr_in == ADDR_CHAN_CTRL &&
                   wdata_in[CHAN_RESET_BIT]);                        // [RULE14]
    end
  end

  always_comb begin
    next_select_reg = select_reg;
    // 0xff always lands in the shared group, whatever the steering
    if (wr_in && addr_in == ADDR_SELECT) begin
      next_select_reg = wdata_in & SELECT_MASK;                      // [RULE12] [RULE17]
    end
    for (int c = 0; c < NUM_CHANNELS; c++) begin
      next_emph[c]  = emph[c];
      next_swing[c] = swing[c];
      next_ovr[c]   = ovr[c];
      next_start[c] = start[c];
      if (hit[c]) begin
        unique case (addr_in)
          ADDR_EMPHASIS:    next_emph[c]  = wdata_in & EMPH_MASK;        // [RULE17]
          ADDR_SWING:       next_swing[c] = wdata_in & SWING_MASK;
          ADDR_ADAPT_OVR:   next_ovr[c]   = wdata_in & ADAPT_OVR_MASK;
          ADDR_ADAPT_START: next_start[c] = wdata_in & ADAPT_START_MASK;
          default: ;
        endcase
      end
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      select_reg <= SELECT_RESET;
      for (int c = 0; c < NUM_CHANNELS; c++) begin
        emph[c]  <= EMPH_RESET;
        swing[c] <= SWING_RESET;
        ovr[c]   <= ADAPT_OVR_RESET;
        start[c] <= ADAPT_START_RESET;
      end
    end else if (ce_in) begin
      select_reg <= next_select_reg;
      emph       <= next_emph;
      swing      <= next_swing;
      ovr        <= next_ovr;
      start      <= next_start;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-channel boost tables and setting decode
  for (genvar g = 0; g < NUM_CHANNELS; g++) begin : g_chan
    assign eff_idx[g] = ovr[g][ADAPT_OVR_BIT] ? start[g][4:0] : 5'h00;   // [RULE1] [RULE2] [RULE4]
    boost_table_mem u_tbl (
      .mclk_in         (mclk_in),
      .ce_in           (ce_in),
      .restore_in      (restore[g]),                                 // [RULE14]
      .wr_en_in        (tbl_wr[g]),                                  // [RULE5]
      .wr_idx_in       (tbl_idx),
      .wr_data_in      (wdata_in),
      .rd_idx_in       (tbl_idx),
      .start_idx_in    (eff_idx[g]),                                 // [RULE3]
      .rd_data_out     (tbl_rd[g]),
      .start_entry_out (tbl_start[g])
    );
    always_ff @(posedge mclk_in) begin
      if (!rstn_in) begin
        adapt_start_idx_out[g*5 +: 5]   <= 5'h00;
        adapt_start_entry_out[g*8 +: 8] <= 8'h00;
        swing_mv_out[g*11 +: 11]        <= SWING_BASE_MV;
        emph_tenth_db_out[g*7 +: 7]     <= 7'h00;
      end else if (ce_in) begin
        adapt_start_idx_out[g*5 +: 5]   <= eff_idx[g];
        adapt_start_entry_out[g*8 +: 8] <= tbl_start[g];             // [RULE5]
        swing_mv_out[g*11 +: 11]        <= 11'(SWING_BASE_MV +
          11'(SWING_STEP_MV * {8'h00, swing[g][2:0]}));              // [RULE6]
        // Magnitude only; sign is always negative or zero
        emph_tenth_db_out[g*7 +: 7]     <= emph[g][EMPH_RANGE_BIT] ?
          EMPH_LOW_RANGE[emph[g][2:0]] :                              // [RULE9] [RULE8]
          EMPH_FULL_RANGE[emph[g][2:0]];                              // [RULE10] [RULE7]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path: one cycle latency to match the registered table read
  always_comb begin
    next_rd_tbl = chan_mode && in_table;
    next_rd_reg = 8'h00;                                             // [RULE17]
    if (addr_in == ADDR_SELECT) begin
      next_rd_reg = select_reg;
    end else if (chan_mode) begin
      unique case (addr_in)
        ADDR_EMPHASIS:    next_rd_reg = emph[chan_sel];
        ADDR_SWING:       next_rd_reg = swing[chan_sel];
        ADDR_ADAPT_OVR:   next_rd_reg = ovr[chan_sel];
        ADDR_ADAPT_START: next_rd_reg = start[chan_sel];
        default:          next_rd_reg = 8'h00;
      endcase
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      rd_tbl_q  <= 1'b0;
      rd_chan_q <= 2'h0;
      rd_reg_q  <= 8'h00;
      rvalid_q  <= 1'b0;
    end else if (ce_in) begin
      rd_tbl_q  <= next_rd_tbl;
      rd_chan_q <= chan_sel;
      rd_reg_q  <= next_rd_reg;
      rvalid_q  <= rd_in;
    end
  end

  assign rdata_out  = rd_tbl_q ? tbl_rd[rd_chan_q] : rd_reg_q;
  assign rvalid_out = rvalid_q;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rstn_in);

  a_idx_no_ovr: assert property ((ce_in && !ovr[0][ADAPT_OVR_BIT]) |=>
    adapt_start_idx_out[4:0] == 5'h00) else $error("start index not zero");   // [RULE1]
  a_idx_ovr: assert property ((ce_in && ovr[2][ADAPT_OVR_BIT]) |=>
    adapt_start_idx_out[14:10] == $past(start[2][4:0])) else $error("start index wrong"); // [RULE2]
  a_swing_val: assert property (ce_in |=> swing_mv_out[10:0] ==
    11'(11'h258 + 11'h064 * $past(swing[0][2:0]))) else $error("swing mismatch");  // [RULE6]
  a_emph_zero: assert property ((ce_in && emph[0][2:0] == 3'h0) |=>
    emph_tenth_db_out[6:0] == 7'h00) else $error("code zero not 0 dB");   // [RULE8]
  a_emph_max: assert property ((ce_in && emph[3] == 8'h07) |=>
    emph_tenth_db_out[27:21] == 7'h78) else $error("strongest not 12 dB");  // [RULE10]
  a_emph_low: assert property ((ce_in && emph[3] == 8'h47) |=>
    emph_tenth_db_out[27:21] == 7'h38) else $error("range max not 5.6 dB"); // [RULE9]
  a_sel_shared: assert property ((wr_in && ce_in && !chan_mode && addr_in == ADDR_SWING) |=>
    $stable(swing[0]) && $stable(swing[3])) else $error("shared write hit channel"); // [RULE15]
  a_sel_chan: assert property ((wr_in && ce_in && chan_mode && !select_reg[3] &&
    chan_sel == 2'h1 && addr_in == ADDR_SWING) |=> $stable(swing[0]) &&
    swing[1] == $past(wdata_in & 8'h07)) else $error("channel steering wrong"); // [RULE16]
  // Restored entry reaches the output three edges later: table, read stage, output stage
  a_tbl_restore: assert property ((ce_in && restore[2]) ##1 ce_in ##1 ce_in |=>
    adapt_start_entry_out[23:16] == BOOST_DEFAULT[$past(eff_idx[2], 2)])
    else $error("table not restored");                                // [RULE14]
  a_undef_zero: assert property ((ce_in && wr_in && hit[2] && addr_in == ADDR_ADAPT_START) |=>
    start[2][7:5] == 3'h0 && start[2][4:0] == $past(wdata_in[4:0]))
    else $error("undefined bits kept");                               // [RULE17]

  c_chan_write: cover property (wr_in && ce_in && chan_mode && addr_in == ADDR_EMPHASIS);
  c_bcast: cover property (wr_in && ce_in && chan_mode && select_reg[SEL_BCAST_BIT]);
  c_ovr_on: cover property (ovr[2][ADAPT_OVR_BIT] && start[2][4:0] != 5'h00);
  c_tbl_write: cover property (|tbl_wr);
endmodule : channel_driver_config_regs

// *** testbench/tb_top.sv ***
// Self-checking bench for the shared and per-channel configuration registers
`timescale 1ns/1ps
module tb_top;
  import chan_cfg_pkg::*;
  logic        mclk_in;
  logic        rstn_in;
  logic        ce_in;
  logic        wr_in;
  logic        rd_in;
  logic [7:0]  addr_in;
  logic [7:0]  wdata_in;
  logic [7:0]  rdata_out;
  logic        rvalid_out;
  logic [19:0] adapt_start_idx_out;
  logic [31:0] adapt_start_entry_out;
  logic [43:0] swing_mv_out;
  logic [27:0] emph_tenth_db_out;
  logic [7:0]  rd_exp_q[$];
  logic [7:0]  rnd;
  int          miscompares;
  int          compares;
  int          seed;
  int          c;
  // Emphasis magnitude in tenths of a dB: row 0 range clear, row 1 range set
  logic [6:0]  emph_tab[2][8] = '{'{7'h00, 7'h0F, 7'h23, 7'h32, 7'h3C, 7'h4B, 7'h5A, 7'h78},
                                  '{7'h00, 7'h09, 7'h14, 7'h1C, 7'h21, 7'h27, 7'h2D, 7'h38}};

  channel_driver_config_regs i_channel_driver_config_regs (
    .mclk_in(mclk_in), .rstn_in(rstn_in), .ce_in(ce_in), .wr_in(wr_in), .rd_in(rd_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .rdata_out(rdata_out), .rvalid_out(rvalid_out),
    .adapt_start_idx_out(adapt_start_idx_out), .adapt_start_entry_out(adapt_start_entry_out),
    .swing_mv_out(swing_mv_out), .emph_tenth_db_out(emph_tenth_db_out));

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    mclk_in = 1'b0;
    forever #2.5 mclk_in = ~mclk_in;
  end

  task automatic print_verdict;
    $display("Compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : print_verdict

  task automatic cmp8(input string n, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : cmp8

  task automatic cmp_fld(input string n, input logic [10:0] e, input logic [10:0] g);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : cmp_fld

  // Only described register addresses are ever written
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk_in);
    wr_in    = 1'b1;
    addr_in  = a;
    wdata_in = d;
    @(negedge mclk_in);
    wr_in = 1'b0;
  endtask : wr

  // Expectation is queued before the strobe can be taken
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge mclk_in);
    rd_exp_q.push_back(e);
    rd_in   = 1'b1;
    addr_in = a;
    @(negedge mclk_in);
    rd_in = 1'b0;
  endtask : rd

  // Entry output lags the start index by one more register stage
  task automatic settle;
    repeat (2) @(negedge mclk_in);
  endtask : settle

  task automatic chk_adapt(input logic [4:0] ei, input logic [7:0] ee);
    cmp_fld("start idx ch2", 11'(ei), 11'(adapt_start_idx_out[10+:5]));
    cmp_fld("start entry ch2", 11'(ee), 11'(adapt_start_entry_out[16+:8]));
  endtask : chk_adapt

  ////////////////////////////////////////////////////////////////////////////////
  always @(negedge mclk_in) begin
    if (rvalid_out === 1'b1) begin
      if (rd_exp_q.size() == 0) begin
        miscompares++;
        $display("[FAIL] rdata expected none seen %h", rdata_out);
      end else begin
        cmp8("rdata", rd_exp_q.pop_front(), rdata_out);
      end
    end
  end

  initial begin
    #200000;
    miscompares++;
    $display("[FAIL] run expected done seen hang");
    print_verdict;
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    seed = 32'h5AF7F206;
    miscompares = 0;
    compares = 0;
    rstn_in = 1'b0;
    ce_in = 1'b1;
    wr_in = 1'b0;
    rd_in = 1'b0;
    addr_in = 8'h00;
    wdata_in = 8'h00;
    repeat (5) @(negedge mclk_in);
    rstn_in = 1'b1;
    settle;
    for (c = 0; c < 4; c++) begin
      cmp_fld("swing rst", 11'h258, swing_mv_out[c*11+:11]);
      cmp_fld("emph rst", 11'h000, 11'(emph_tenth_db_out[c*7+:7]));
      cmp_fld("idx rst", 11'h000, 11'(adapt_start_idx_out[c*5+:5]));
      cmp_fld("entry rst", 11'(BOOST_DEFAULT[0]), 11'(adapt_start_entry_out[c*8+:8]));
    end
    // Shared group selected: channel address is neither written nor read
    wr(ADDR_SWING, 8'h07);
    rd(ADDR_SWING, 8'h00);
    wr(ADDR_SELECT, 8'hF0);
    rd(ADDR_SELECT, 8'h00);
    settle;
    cmp_fld("swing shared", 11'h258, swing_mv_out[10:0]);
    for (int code = 0; code < 8; code++) begin
      c = code % 4;
      rnd = 8'($random(seed));
      wr(ADDR_SELECT, 8'(4 + c));
      wr(ADDR_SWING, {rnd[7:3], 3'(code)});
      rd(ADDR_SWING, {5'h00, 3'(code)});
      settle;
      cmp_fld("swing", 11'h258 + 11'h064 * 11'(code), swing_mv_out[c*11+:11]);
    end
    for (c = 0; c < 4; c++)
      cmp_fld("swing kept", 11'h258 + 11'h064 * 11'(c + 4), swing_mv_out[c*11+:11]);
    for (int i = 0; i < 16; i++) begin
      c = i % 4;
      rnd = 8'($random(seed));
      wr(ADDR_SELECT, 8'(4 + c));
      wr(ADDR_EMPHASIS, {rnd[7], i[3], rnd[5:3], i[2:0]});
      rd(ADDR_EMPHASIS, {1'b0, i[3], 3'h0, i[2:0]});
      settle;
      cmp_fld("emph", 11'(emph_tab[i[3]][i[2:0]]),
              11'(emph_tenth_db_out[c*7+:7]));
    end
    wr(ADDR_SELECT, 8'h06);
    wr(ADDR_ADAPT_START, 8'hF5);
    rd(ADDR_ADAPT_START, 8'h15);
    settle;
    chk_adapt(5'h00, BOOST_DEFAULT[0]);
    wr(ADDR_ADAPT_OVR, 8'hFF);
    rd(ADDR_ADAPT_OVR, 8'h08);
    settle;
    chk_adapt(5'h15, BOOST_DEFAULT[21]);
    rnd = BOOST_DEFAULT[21] ^ (8'($random(seed)) | 8'h01);
    wr(ADDR_TABLE_FIRST + 8'h15, rnd);
    rd(ADDR_TABLE_FIRST + 8'h15, rnd);
    rd(ADDR_TABLE_LAST, BOOST_DEFAULT[31]);
    chk_adapt(5'h15, rnd);
    wr(ADDR_CHAN_CTRL, 8'h04);
    rd(ADDR_CHAN_CTRL, 8'h00);
    rd(ADDR_TABLE_FIRST + 8'h15, BOOST_DEFAULT[21]);
    settle;
    chk_adapt(5'h15, BOOST_DEFAULT[21]);
    cmp_fld("idx ch0", 11'h000, 11'(adapt_start_idx_out[4:0]));
    // Broadcast write reaches every channel copy
    wr(ADDR_SELECT, 8'h0C);
    wr(ADDR_SWING, 8'h05);
    settle;
    for (c = 0; c < 4; c++)
      cmp_fld("swing bcast", 11'h44C, swing_mv_out[c*11+:11]);
    ce_in = 1'b0;
    wr(ADDR_SWING, 8'h01);
    ce_in = 1'b1;
    settle;
    cmp_fld("swing frozen", 11'h44C, swing_mv_out[10:0]);
    if (rd_exp_q.size() != 0) begin
      miscompares++;
      $display("[FAIL] pending reads expected 0 seen %0d", rd_exp_q.size());
    end
    print_verdict;
  end
endmodule : tb_top
